/* logic/mlau_check.sv */
`timescale 1ns/1ns
`default_nettype none
module mlau_check
	import mlau_pkg::*;
(
	input  wire logic                    valid,   // New result present
	input  wire logic [3:0]              chan,    // Result channel
	input  wire logic [DW-1:0]           value,   // Result, two's complement
	input  wire logic [1:0]              ncells,  // Cell count code
	input  wire logic [NAL-1:0][DW-1:0]  lim,     // Limit levels
	output logic      [NAL-1:0]          viol     // Level crossed now
);
	import mlau_pkg::*;

	for (genvar i = 0; i < NAL; i++) begin : g_al
		logic src_ok;
		logic below;
		logic above;
		// Cell alarms share one level pair across every populated cell
		if (i == AL_CELL_UV || i == AL_CELL_OV) begin : g_cell
			assign src_ok = chan <= {2'b00, ncells};
		end else begin : g_one
			assign src_ok = chan == AL_CHAN[i];
		end
		// Temperature levels are raw codes in the same scale
		assign below = $signed(value) < $signed(lim[i]);
		assign above = $signed(value) > $signed(lim[i]);
		assign viol[i] = valid && src_ok && (AL_BELOW[i] ? below : above);
	end
endmodule
`default_nettype wire

/* logic/mlau_seq.sv */
`timescale 1ns/1ns
`default_nettype none
module mlau_seq
	import mlau_pkg::*;
#(
	parameter int SLOT = SLOT_CYC
) (
	input  wire logic       pclk,     // System clock
	input  wire logic       presetn,  // Async reset, active low
	output logic            start,    // Conversion start pulse
	output logic [3:0]      chan      // Channel being converted
);
	import mlau_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic [3:0]  chan;
		logic        start;
	} mlau_seq_st_t;

	mlau_seq_st_t s_q, s_d;
	logic [3:0]   prev_chan_q;

	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		if (s_q.cnt == 16'(SLOT - 1)) begin
			s_d.cnt = '0;
			s_d.start = 1'b1;
			s_d.chan = (s_q.chan == CH_DTEMP) ? CH_CELL1 : s_q.chan + 4'h1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.chan <= CH_DTEMP;
			prev_chan_q <= CH_DTEMP;
		end else begin
			s_q <= s_d;
			if (s_q.start)
				prev_chan_q <= s_q.chan;
		end
	end

	assign start = s_q.start;
	assign chan  = s_q.chan;

	property p_rotate;
		@(posedge pclk) disable iff (!presetn)
		s_q.start |-> s_q.chan == ((prev_chan_q == CH_DTEMP) ? CH_CELL1 : prev_chan_q + 4'h1);
	endproperty
	a_rotate: assert property (p_rotate) else $error("Channel rotation skipped");
endmodule
`default_nettype wire

/* logic/mlau_top.sv */
// Summary of operation
// - Disabled limit never sets its alarm.
// - Enabled crossing latches its alarm flag.
// - Clear register write-one clears; zero ignored.
// - Mask bit zero also clears that flag.
// - Flags register reads all uncleared alarms.
// - Each voltage has under and over levels.
// - All cells share one level pair.
// - Input current checked against overcurrent level.
// - Charge current checked against undercurrent level.
// - Temperature has separate cold and hot levels.
// - Temperature code maps linearly to Celsius.
// - Aux input has under/over enable bits.
// - Control bit routes aux through buffer.
// - All alarms disabled after reset.
// - Enabled crossing also raises the alert.
// - Straps read back as cell count.
// - Shunt threshold resets to 2.7V code.
// - Feedback reference defaults 1.2V, writable.
// - Any active shunt lowers charge current.
// - Alert released after alert response read.
// - Eleven channels converted in rotation, ~18ms.
// - Results are signed 16-bit, compared signed.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module mlau_top
	import mlau_pkg::*;
#(
	parameter int SLOT = SLOT_CYC
) (
	input  wire logic           pclk,           // System clock, 25 MHz
	input  wire logic           presetn,        // Async reset, active low
	input  wire logic           psel,           // APB select
	input  wire logic           penable,        // APB enable
	input  wire logic           pwrite,         // APB write
	input  wire logic [AW-1:0]  paddr,          // APB byte address
	input  wire logic [31:0]    pwdata,         // APB write data
	output logic      [31:0]    prdata,         // APB read data
	output logic                pready,         // APB ready
	output logic                pslverr,        // APB error
	output logic                adc_start,      // Start conversion pulse
	output logic      [3:0]     adc_chan,       // Channel to convert
	input  wire logic           adc_done,       // Result valid pulse
	input  wire logic [DW-1:0]  adc_data,       // Signed result
	input  wire logic           ara_done,       // Alert response answered
	input  wire logic           alert_in,       // Alert pin level
	output logic                alert_out,      // Alert pin drive value
	output logic                alert_oe,       // Alert pin pulled low
	input  wire logic           cell_strap_low, // Cell count strap bit 0
	input  wire logic           cell_strap_high,// Cell count strap bit 1
	input  wire logic [3:0]     shunt_active,   // Per-cell shunt on
	output logic                charge_reduce,  // Lower charge current
	output logic                aux_buffer_en,  // Aux via buffer
	output logic      [DW-1:0]  shunt_threshold,// Shunt level code
	output logic      [DW-1:0]  fb_reference    // Stack feedback code
);
	import mlau_pkg::*;

	typedef struct packed {
		logic                   aux_buf;
		logic [NAL-1:0]         mask;
		logic [NAL-1:0]         flags;
		logic [NAL-1:0][DW-1:0] lim;
		logic [NCH-1:0][DW-1:0] meas;
		logic [DW-1:0]          shunt;
		logic [DW-1:0]          fbref;
		logic                   alert;
		logic [31:0]            prd;
		logic                   prdy;
		logic                   perr;
		logic [1:0]             strap_m;
		logic [1:0]             strap;
		logic                   apin_m;
		logic                   apin;
		logic [3:0]             sh_m;
		logic [3:0]             sh;
		logic                   chg_red;
	} mlau_top_st_t;

	mlau_top_st_t   s_q;
	mlau_top_st_t   s_d;
	logic           seq_start;
	logic [3:0]     seq_chan;
	logic [NAL-1:0] viol;
	logic [NAL-1:0] hit;
	logic [NAL-1:0] clr;
	logic           wr;
	logic           setup;
	logic [3:0]     idx;

	mlau_seq #(
		.SLOT  (SLOT)
	) u_seq (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (seq_start),
		.chan    (seq_chan)
	);

	mlau_check u_check (
		.valid  (adc_done),
		.chan   (seq_chan),
		.value  (adc_data),
		.ncells (s_q.strap),
		.lim    (s_q.lim),
		.viol   (viol)
	);

	// Access takes effect on the single pready cycle
	assign wr    = psel && penable && s_q.prdy && pwrite;
	assign setup = psel && !penable;
	assign idx   = paddr[5:2];

	always_comb begin
		s_d = s_q;
		clr = '0;

		// Pin inputs pass two flops before anything reads them
		s_d.strap_m = {cell_strap_high, cell_strap_low};
		s_d.strap   = s_q.strap_m;
		s_d.apin_m  = alert_in;
		s_d.apin    = s_q.apin_m;
		s_d.sh_m    = shunt_active;
		s_d.sh      = s_q.sh_m;
		s_d.chg_red = |s_q.sh;

		if (adc_done && seq_chan < 4'(NCH))
			s_d.meas[seq_chan] = adc_data;

		if (wr) begin
			if (paddr == A_CTL)
				s_d.aux_buf = pwdata[CTL_AUX_BUF];
			if (paddr == A_MASK)
				s_d.mask = pwdata[NAL-1:0];
			if (paddr == A_CLR)
				clr = pwdata[NAL-1:0];
			if (paddr == A_SHUNT)
				s_d.shunt = pwdata[DW-1:0];
			if (paddr == A_FBREF)
				s_d.fbref = pwdata[DW-1:0];
			if (paddr[7:6] == LIM_PAGE && idx < 4'(NAL))
				s_d.lim[idx] = pwdata[DW-1:0];
		end

		// New mask applies at once so a disabling write can never latch
		hit = viol & s_d.mask;
		// Clear loses to a crossing in the same cycle; disable wins over it
		s_d.flags = (s_q.flags & ~clr & s_d.mask) | hit;
		s_d.alert = (s_q.alert && !ara_done) || (|hit);

		s_d.prdy = setup;
		s_d.perr = 1'b0;
		if (setup) begin
			s_d.prd = '0;
			unique case (paddr)
				A_CTL:    s_d.prd[CTL_AUX_BUF] = s_q.aux_buf;
				A_MASK:   s_d.prd[NAL-1:0] = s_q.mask;
				A_CLR:    s_d.prd = '0;
				A_FLAGS:  s_d.prd[NAL-1:0] = s_q.flags;
				A_NCELLS: s_d.prd[1:0] = s_q.strap;
				A_SHUNT:  s_d.prd[DW-1:0] = s_q.shunt;
				A_FBREF:  s_d.prd[DW-1:0] = s_q.fbref;
				A_STAT: begin
					s_d.prd[ST_PIN]     = s_q.apin;
					s_d.prd[ST_ALERT]   = s_q.alert;
					s_d.prd[ST_CHG_RED] = s_q.chg_red;
				end
				default: begin
					if (paddr[7:6] == LIM_PAGE && idx < 4'(NAL))
						s_d.prd[DW-1:0] = s_q.lim[idx];
					else if (paddr[7:6] == MEAS_PAGE && idx < 4'(NCH))
						s_d.prd[DW-1:0] = s_q.meas[idx];
					else
						s_d.perr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.mask  <= MASK_RST;
			s_q.shunt <= SHUNT_RST;
			s_q.fbref <= FBREF_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata          = s_q.prd;
	assign pready          = s_q.prdy;
	assign pslverr         = s_q.perr;
	assign adc_start       = seq_start;
	assign adc_chan        = seq_chan;
	// Open drain: only ever pulls low
	assign alert_out       = 1'b0;
	assign alert_oe        = s_q.alert;
	assign charge_reduce   = s_q.chg_red;
	assign aux_buffer_en   = s_q.aux_buf;
	assign shunt_threshold = s_q.shunt;
	assign fb_reference    = s_q.fbref;

	property p_flag_in_mask;
		@(posedge pclk) disable iff (!presetn)
		(s_q.flags & ~s_q.mask) == '0;
	endproperty
	a_flag_in_mask: assert property (p_flag_in_mask) else $error("Flag set outside mask");

	property p_latch;
		@(posedge pclk) disable iff (!presetn)
		|hit |=> ((s_q.flags & $past(hit)) == $past(hit)) && s_q.alert;
	endproperty
	a_latch: assert property (p_latch) else $error("Crossing not latched");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr && (paddr == A_CLR || paddr == A_MASK))
			|=> (($past(s_q.flags) & ~s_q.flags) == '0);
	endproperty
	a_hold: assert property (p_hold) else $error("Flag dropped without clear");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == A_CLR && !(|viol)
			|=> (s_q.flags & $past(pwdata[NAL-1:0])) == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("Write-one clear failed");

	property p_mask_clear;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == A_MASK
			|=> (s_q.flags & ~$past(pwdata[NAL-1:0])) == '0;
	endproperty
	a_mask_clear: assert property (p_mask_clear) else $error("Mask write kept flag");

	property p_read_flags;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == A_FLAGS
			|=> pready && prdata[NAL-1:0] == $past(s_q.flags) && !pslverr;
	endproperty
	a_read_flags: assert property (p_read_flags) else $error("Flag readback wrong");

	property p_ara;
		@(posedge pclk) disable iff (!presetn)
		ara_done && !(|hit) |=> !alert_oe;
	endproperty
	a_ara: assert property (p_ara) else $error("Alert kept after response");

	property p_alert_cause;
		@(posedge pclk) disable iff (!presetn)
		$rose(alert_oe) |-> $past(|hit);
	endproperty
	a_alert_cause: assert property (p_alert_cause) else $error("Alert without crossing");

	property p_shunt;
		@(posedge pclk) disable iff (!presetn)
		(|shunt_active) [*3] |=> charge_reduce;
	endproperty
	a_shunt: assert property (p_shunt) else $error("Charge not reduced");

	property p_aux_buf;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == A_CTL |=> aux_buffer_en == $past(pwdata[CTL_AUX_BUF]);
	endproperty
	a_aux_buf: assert property (p_aux_buf) else $error("Aux buffer select wrong");
endmodule
`default_nettype wire

/* shared/mlau_pkg.sv */
package mlau_pkg;
	localparam int DW  = 16;
	localparam int NCH = 11;
	localparam int NAL = 14;
	localparam int AW  = 8;

	// Channel indices in conversion order
	localparam logic [3:0] CH_CELL1 = 4'h0;
	localparam logic [3:0] CH_CELL4 = 4'h3;
	localparam logic [3:0] CH_AUX   = 4'h4;
	localparam logic [3:0] CH_VIN   = 4'h5;
	localparam logic [3:0] CH_STACK = 4'h6;
	localparam logic [3:0] CH_VOUT  = 4'h7;
	localparam logic [3:0] CH_IIN   = 4'h8;
	localparam logic [3:0] CH_ICHG  = 4'h9;
	localparam logic [3:0] CH_DTEMP = 4'ha;

	// Alarm bit positions; limit register i guards alarm bit i
	localparam int AL_CELL_UV  = 0;
	localparam int AL_CELL_OV  = 1;
	localparam int AL_AUX_UV   = 2;
	localparam int AL_AUX_OV   = 3;
	localparam int AL_VIN_UV   = 4;
	localparam int AL_VIN_OV   = 5;
	localparam int AL_STACK_UV = 6;
	localparam int AL_STACK_OV = 7;
	localparam int AL_VOUT_UV  = 8;
	localparam int AL_VOUT_OV  = 9;
	localparam int AL_IIN_OC   = 10;
	localparam int AL_ICHG_UC  = 11;
	localparam int AL_DT_COLD  = 12;
	localparam int AL_DT_HOT   = 13;

	// Alarms that fire below their level; the rest fire above it
	localparam logic [NAL-1:0] AL_BELOW = 14'h1955;
	// Source channel per alarm (cell alarms use the cell range instead)
	localparam logic [NAL-1:0][3:0] AL_CHAN = {
		CH_DTEMP, CH_DTEMP, CH_ICHG, CH_IIN, CH_VOUT, CH_VOUT,
		CH_STACK, CH_STACK, CH_VIN, CH_VIN, CH_AUX, CH_AUX,
		CH_CELL1, CH_CELL1};

	// Register byte offsets
	localparam logic [AW-1:0] A_CTL    = 8'h00;
	localparam logic [AW-1:0] A_MASK   = 8'h04;
	localparam logic [AW-1:0] A_CLR    = 8'h08;
	localparam logic [AW-1:0] A_FLAGS  = 8'h0c;
	localparam logic [AW-1:0] A_NCELLS = 8'h10;
	localparam logic [AW-1:0] A_SHUNT  = 8'h14;
	localparam logic [AW-1:0] A_FBREF  = 8'h18;
	localparam logic [AW-1:0] A_STAT   = 8'h1c;
	localparam logic [1:0]    LIM_PAGE  = 2'b01;
	localparam logic [1:0]    MEAS_PAGE = 2'b10;

	// Field positions
	localparam int CTL_AUX_BUF = 0;
	localparam int ST_PIN      = 0;
	localparam int ST_ALERT    = 1;
	localparam int ST_CHG_RED  = 2;

	// Reset values
	localparam logic [NAL-1:0] MASK_RST  = 14'h0000;
	localparam logic [DW-1:0]  SHUNT_RST = 16'h0a8c;
	localparam logic [DW-1:0]  FBREF_RST = 16'h04b0;

	// Die temperature code: Celsius = 0.028 * code - 251.4
	localparam int TEMP_GAIN_MILLI = 28;
	localparam int TEMP_OFS_DECI   = 2514;

	// Conversion slot per channel
	localparam int SLOT_TIME_US = 1600;
	localparam int CLK_KHZ      = 25000;
	localparam int SLOT_CYC     = SLOT_TIME_US * CLK_KHZ / 1000;
endpackage

/* verif/mlau_adc_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mlau_adc_model
	import mlau_pkg::*;
(
	input  wire logic                   pclk,      // System clock
	input  wire logic                   presetn,   // Reset, active low
	input  wire logic                   adc_start, // Conversion start
	input  wire logic [3:0]             adc_chan,  // Channel converted
	input  wire logic                   slow,      // Late answer
	input  wire logic [NCH-1:0][DW-1:0] vals,      // Input per channel
	output logic                        adc_done,  // Result pulse
	output logic      [DW-1:0]          adc_data   // Result
);
	int cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			adc_done <= 1'b0;
			adc_data <= 16'h0000;
		end else if (adc_start) begin
			cnt <= slow ? 9 : 2;
			adc_done <= 1'b0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			adc_done <= 1'b1;
			adc_data <= vals[adc_chan];
		end else begin
			adc_done <= 1'b0;
			// Stale data never looks valid
			if (adc_done)
				adc_data <= ~adc_data;
		end
	end
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import mlau_pkg::*;
	logic                   pclk, presetn, psel, penable, pwrite, ara_done, slow;
	logic [AW-1:0]          paddr;
	logic [31:0]            pwdata, prdata, rd_q;
	logic                   pready, pslverr, err_q, adc_start, adc_done, alert_oe;
	logic [3:0]             adc_chan, shunt_active;
	logic [DW-1:0]          adc_data, shunt_threshold, fb_reference;
	logic                   charge_reduce, aux_buffer_en;
	logic [1:0]             strap;
	logic [NCH-1:0][DW-1:0] vals;
	logic [NAL-1:0][DW-1:0] lim;
	logic [NAL-1:0]         msk, expf;
	int                     error_cnt, comparisons, seed, r, i;

	mlau_top #(.SLOT(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
		.ara_done(ara_done), .alert_in(!alert_oe), .alert_out(), .alert_oe(alert_oe),
		.cell_strap_low(strap[0]), .cell_strap_high(strap[1]),
		.shunt_active(shunt_active), .charge_reduce(charge_reduce),
		.aux_buffer_en(aux_buffer_en), .shunt_threshold(shunt_threshold),
		.fb_reference(fb_reference));
	mlau_adc_model adc_u (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
		.adc_chan(adc_chan), .slow(slow), .vals(vals), .adc_done(adc_done),
		.adc_data(adc_data));

	always #20 pclk = ~pclk;

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD reg t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD pin t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			error_cnt++;
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic set_lims();
		for (int k = 0; k < NAL; k++)
			apb(1'b1, 8'h40 + 8'(4 * k), {16'h0000, lim[k]});
	endtask

	// Which alarms the present inputs cross, compared signed
	function automatic logic [NAL-1:0] viol_f();
		int v, l;
		logic [NAL-1:0] res;
		res = '0;
		for (int k = 0; k < NAL; k++)
			for (int c = 0; c < NCH; c++)
				if ((k < 2) ? (c <= int'(strap)) : (c == int'(AL_CHAN[k]))) begin
					v = int'($signed(vals[c]));
					l = int'($signed(lim[k]));
					if (AL_BELOW[k] ? (v < l) : (v > l))
						res[k] = 1'b1;
				end
		return res;
	endfunction

	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; ara_done = 0; slow = 0; strap = 0; shunt_active = 0;
		error_cnt = 0; comparisons = 0; seed = 18; vals = '0; lim = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, A_MASK, 0); chk_reg(rd_q, 32'h0);
		apb(0, A_SHUNT, 0); chk_reg(rd_q, {16'h0, SHUNT_RST});
		chk_pin(shunt_threshold, SHUNT_RST);
		apb(0, A_FBREF, 0); chk_reg(rd_q, {16'h0, FBREF_RST});
		apb(1, A_FBREF, 32'h0123); apb(0, A_FBREF, 0);
		chk_pin(fb_reference, 16'h0123);
		apb(0, 8'h3c, 0); chk_reg({31'h0, err_q}, 32'h1);
		for (i = 0; i < 4; i++) begin
			strap <= 2'(i);
			repeat (4) @(posedge pclk);
			apb(0, A_NCELLS, 0); chk_reg(rd_q, i);
			shunt_active <= 4'($random(seed));
			repeat (4) @(posedge pclk);
			#1 chk_pin({15'h0, charge_reduce}, {15'h0, |shunt_active});
			apb(1, A_CTL, i); apb(0, A_CTL, 0);
			chk_pin({15'h0, aux_buffer_en}, 16'(i & 1));
		end
		// Every input equal to x, limits one below: only upper alarms trip
		vals = {NCH{16'h8123}};
		lim = {NAL{16'h8122}};
		set_lims();
		apb(1, A_MASK, 32'h3fff);
		repeat (260) @(posedge pclk);
		expf = ~AL_BELOW;
		apb(0, A_FLAGS, 0); chk_reg(rd_q, {18'h0, expf});
		#1 chk_pin({15'h0, alert_oe}, 16'h1);
		lim = {NAL{16'h8123}};
		set_lims();
		apb(1, A_CLR, 0); apb(0, A_FLAGS, 0); chk_reg(rd_q, {18'h0, expf});
		apb(1, A_CLR, 32'h00aa); apb(0, A_FLAGS, 0);
		expf = expf & ~14'h00aa;
		chk_reg(rd_q, {18'h0, expf});
		apb(1, A_MASK, 32'h3f00); apb(0, A_FLAGS, 0);
		expf = expf & 14'h3f00;
		chk_reg(rd_q, {18'h0, expf});
		@(posedge pclk) ara_done <= 1'b1;
		@(posedge pclk) ara_done <= 1'b0;
		repeat (260) @(posedge pclk);
		#1 chk_pin({15'h0, alert_oe}, 16'h0);
		apb(0, A_FLAGS, 0); chk_reg(rd_q, {18'h0, expf});
		for (r = 0; r < 4; r++) begin
			slow <= r[0];
			strap <= 2'($random(seed));
			for (i = 0; i < NCH; i++)
				vals[i] = 16'($random(seed));
			for (i = 0; i < NAL; i++)
				lim[i] = 16'($random(seed));
			msk = 14'($random(seed));
			set_lims();
			apb(1, A_MASK, {18'h0, msk});
			apb(1, A_CLR, 32'h3fff);
			// Alert from crossings before the clear stays until answered
			@(posedge pclk) ara_done <= 1'b1;
			@(posedge pclk) ara_done <= 1'b0;
			repeat (260) @(posedge pclk);
			expf = viol_f() & msk;
			apb(0, A_FLAGS, 0); chk_reg(rd_q, {18'h0, expf});
			#1 chk_pin({15'h0, alert_oe}, {15'h0, |expf});
			apb(0, A_STAT, 0);
			chk_reg(rd_q, {29'h0, |shunt_active, |expf, !(|expf)});
			for (i = 0; i < NCH; i++) begin
				apb(0, 8'h80 + 8'(4 * i), 0);
				chk_reg(rd_q, {16'h0, vals[i]});
			end
		end
		wrap_up();
	end
endmodule
`default_nettype wire
